// ---- rtl/annunc_pkg.sv ----
// Shared constants and types for the front-panel annunciation logic
package annunc_pkg;

    // Clock rate and derived timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned FLASH_TIME_MS = 5000;
    localparam int unsigned FLASH_CYCLES = FLASH_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned LAMP_TEST_TIME_MS = 5000;
    localparam int unsigned LAMP_TEST_CYCLES = LAMP_TEST_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned WATCHDOG_TIME_MS = 100;
    localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_TIME_MS * (CLK_HZ / 1000);

    // Display codes
    typedef enum logic [3:0] {
        code_boot = 4'h0,
        code_self_test = 4'h1,
        code_wait_shm = 4'h2,
        code_shm_test = 4'h3,
        code_irq_test = 4'h4,
        code_bus_init = 4'h5,
        code_wait_net = 4'h6,
        code_wait_host = 4'h7,
        code_addr_gen = 4'h8,
        code_active = 4'h9,
        code_addr_err = 4'ha,
        code_bus_err = 4'hb,
        code_parity_err = 4'hc,
        code_run_err = 4'hd,
        code_exc_err = 4'he,
        code_temp_err = 4'hf
    } disp_code_e;

    // Error classes reported by the processor
    typedef struct packed {
        logic addr_err;
        logic bus_err;
        logic parity_err;
        logic checksum_err;
        logic run_err;
        logic exc_err;
        logic temp_err;
    } err_evt_s;

    // Lamp outputs
    typedef struct packed {
        logic fault_lamp_a;
        logic fault_lamp_b;
        logic halt_lamp;
        logic activity_lamp;
    } lamps_s;

    localparam int unsigned DIAG_W = 16;
    localparam logic [3:0] RESET_CODE = 4'h0;
    localparam logic [7:0] PWM_RESET = 8'h00;

endpackage

// ---- rtl/status_annunciation_logic.sv ----
// Front-panel lamps, status digit, watchdog and diagnosis bit holding
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
module status_annunciation_logic #(
    parameter int unsigned FLASH_LEN = annunc_pkg::FLASH_CYCLES,
    parameter int unsigned LAMP_TEST_LEN = annunc_pkg::LAMP_TEST_CYCLES,
    parameter int unsigned BLINK_LEN = annunc_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned WATCHDOG_LEN = annunc_pkg::WATCHDOG_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Processor status
    input wire logic cpu_halted,
    input wire logic [7:0] cpu_load,
    input wire logic step_valid,
    input wire logic [3:0] step_code,
    input wire logic wdog_kick,
    input wire annunc_pkg::err_evt_s err_evt,
    // Diagnosis sources
    input wire logic bus_if_fault,
    input wire logic proc_fault,
    input wire logic host_data_server_fault_set,
    input wire logic host_data_server_fault_clr,
    input wire logic [annunc_pkg::DIAG_W-1:0] diag_cause,
    input wire logic [annunc_pkg::DIAG_W-1:0] diag_history_mask,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // Outputs
    output annunc_pkg::lamps_s lamps,
    output logic [6:0] seg,
    output logic [3:0] disp_code,
    output logic restart_req,
    output logic [annunc_pkg::DIAG_W-1:0] diag_bits,
    output logic [31:0] reg_rdata
);
    import annunc_pkg::*;

    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_DIAG = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Error decode and restart

    logic restart_err;
    logic any_err;
    logic [3:0] err_code;
    logic [31:0] wd_cnt;
    logic wd_expire;
    logic lamp_test;
    logic [31:0] lt_cnt;

    // Error inputs are single-cycle pulses from the processor on this clock
    // Priority: a restarting error beats a checksum report in the same cycle
    always_comb begin
        err_code = code_temp_err;
        if (err_evt.addr_err) begin
            err_code = code_addr_err;
        end else if (err_evt.bus_err) begin
            err_code = code_bus_err;
        end else if (err_evt.run_err) begin
            err_code = code_run_err;
        end else if (err_evt.exc_err) begin
            err_code = code_exc_err;
        end else if (err_evt.parity_err || err_evt.checksum_err) begin
            err_code = code_parity_err;
        end
    end

    assign restart_err = err_evt.addr_err | err_evt.bus_err | err_evt.run_err
        | err_evt.exc_err | err_evt.parity_err;
    assign any_err = |err_evt;
    // A kick in the expiry cycle still counts, so a late but present service wins
    assign wd_expire = (wd_cnt == WATCHDOG_LEN - 1) && !wdog_kick;

    // Watchdog only runs once the lamp test is over
    always_ff @(posedge core_clk) begin
        if (!rst_b || wdog_kick || lamp_test || restart_req) begin
            wd_cnt <= 32'h0;
        end else if (!wd_expire) begin
            wd_cnt <= wd_cnt + 32'h1;
        end
    end

    // Restart pulse to the processing section: one cycle for an error, two for watchdog expiry
    // Registered so the processing section never sees a combinational glitch
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            restart_req <= 1'b0;
        end else begin
            restart_req <= wd_expire | restart_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-up lamp test
    // Its length also sets the walk speed: seven segment steps share it

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lt_cnt <= 32'h0;
            lamp_test <= 1'b1;
        end else if (lamp_test) begin
            if (lt_cnt == LAMP_TEST_LEN - 1) begin
                lamp_test <= 1'b0;
            end else begin
                lt_cnt <= lt_cnt + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display code and flash

    logic [31:0] flash_cnt;
    logic flashing;
    logic [3:0] flash_code;
    logic [31:0] blink_cnt;
    logic blink_on;
    logic active;

    // Code register: restart returns to boot code, errors override steps
    always_ff @(posedge core_clk) begin
        if (!rst_b || restart_req) begin
            disp_code <= RESET_CODE;
        end else if (any_err) begin
            disp_code <= err_code;
        end else if (step_valid && !flashing) begin
            disp_code <= step_code;
        end
    end

    // A new fault in the middle of a flash starts the full window again
    // A fault holds the digit flashing; restart is taken after the pulse
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flash_cnt <= 32'h0;
            flashing <= 1'b0;
        end else if (any_err) begin
            flash_cnt <= 32'h0;
            flashing <= 1'b1;
        end else if (flashing) begin
            if (flash_cnt == FLASH_LEN - 1) begin
                flashing <= 1'b0;
            end else begin
                flash_cnt <= flash_cnt + 32'h1;
            end
        end
    end

    // Copy of the fault code for the flash: the restart pulse zeroes the code
    // register one cycle after the error, which would otherwise hide the cause
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flash_code <= RESET_CODE;
        end else if (any_err) begin
            flash_code <= err_code;
        end
    end

    // Blink phase restarts with every flash so the first half-period is lit
    always_ff @(posedge core_clk) begin
        if (!rst_b || !flashing) begin
            blink_cnt <= 32'h0;
            blink_on <= 1'b1;
        end else if (blink_cnt == BLINK_LEN - 1) begin
            blink_cnt <= 32'h0;
            blink_on <= !blink_on;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    assign active = (disp_code == code_active);

    // Hex digit to segment pattern (gfedcba)
    function automatic logic [6:0] hex_seg(input logic [3:0] c);
        logic [6:0] s;
        s = 7'h00;
        unique case (c)
            4'h0: s = 7'h3f;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;
            4'ha: s = 7'h77;
            4'hb: s = 7'h7c;
            4'hc: s = 7'h39;
            4'hd: s = 7'h5e;
            4'he: s = 7'h79;
            4'hf: s = 7'h71;
        endcase
        return s;
    endfunction

    // During lamp test segments are switched on one after another
    // The last step lights all seven, matching the all-on lamps
    logic [6:0] walk_seg;
    logic [2:0] walk_idx;
    assign walk_idx = 3'(lt_cnt / ((LAMP_TEST_LEN + 6) / 7));

    generate
        for (genvar i = 0; i < 7; i++) begin : g_walk
            assign walk_seg[i] = (walk_idx >= 3'(i));
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            seg <= 7'h7f;
        end else if (lamp_test) begin
            seg <= walk_seg;
        end else if (flashing) begin
            // Flash shows the latched fault, not the already reset code register
            seg <= blink_on ? hex_seg(flash_code) : 7'h00;
        end else begin
            seg <= hex_seg(disp_code);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamps

    logic host_fault;
    logic [7:0] pwm_cnt;
    logic fault_on;

    // The register port and the host pulses both reach this one flag
    // Host flag: set wins over a simultaneous clear; survives restarts
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            host_fault <= 1'b0;
        end else if (host_data_server_fault_set || (reg_wr && reg_addr == REG_CTRL
            && reg_wdata[0])) begin
            host_fault <= 1'b1;
        end else if (host_data_server_fault_clr || (reg_wr && reg_addr == REG_CTRL)) begin
            host_fault <= 1'b0;
        end
    end

    // Free 8-bit ramp; a 256-cycle period is far too fast for the eye to see flicker
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pwm_cnt <= PWM_RESET;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h1;
        end
    end

    // One shared term drives both red lamps, so they can never disagree
    assign fault_on = bus_if_fault
        | proc_fault
        | !active
        | host_fault;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lamps <= '1;
        end else if (lamp_test) begin
            lamps <= '1;
        end else begin
            lamps.fault_lamp_a <= fault_on;
            lamps.fault_lamp_b <= fault_on;
            lamps.halt_lamp <= cpu_halted;
            // Duty is load plus one out of 256; even a zero load still shows a glimmer
            lamps.activity_lamp <= !cpu_halted && (pwm_cnt <= cpu_load);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Background diagnosis bits
    // Mask bit high: history bit, kept until a restart even if the cause goes away
    // Mask bit low: static bit, a registered copy of its cause

    generate
        for (genvar i = 0; i < DIAG_W; i++) begin : g_diag
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    diag_bits[i] <= 1'b0;
                end else if (diag_history_mask[i]) begin
                    if (diag_cause[i]) begin
                        diag_bits[i] <= 1'b1;
                    end else if (restart_req) begin
                        diag_bits[i] <= 1'b0;
                    end
                end else begin
                    diag_bits[i] <= diag_cause[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, data in the cycle after the strobe
    // Writes land only at the control offset; status and diagnosis are read-only

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {22'h0, flashing, lamp_test, host_fault,
                    cpu_halted, disp_code, restart_req, active};
                REG_DIAG: reg_rdata <= {16'h0, diag_bits};
                REG_CTRL: reg_rdata <= {31'h0, host_fault};
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule

// ---- sim/panel_observer.sv ----
// Operator view of the front panel: digit changes and activity lamp on-time
`timescale 1ns/10ps
module panel_observer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Panel as the operator sees it
    input wire logic [6:0] seg,
    input wire annunc_pkg::lamps_s lamps,
    // Running tallies for the bench
    output logic [15:0] seg_changes,
    output logic [15:0] act_on
);
    import annunc_pkg::*;
    logic [6:0] seg_prev;

    // A flashing digit shows up as a stream of segment changes
    always_ff @(posedge core_clk) begin
        seg_prev <= seg;
        if (!rst_b) begin
            seg_changes <= 16'h0;
            act_on <= 16'h0;
        end else begin
            seg_changes <= seg_changes + 16'(seg != seg_prev);
            act_on <= act_on + 16'(lamps.activity_lamp);
        end
    end
endmodule

// ---- sim/status_annunciation_logic_properties.sv ----
// Port-level assertions for the annunciation block
`timescale 1ns/10ps
module annunc_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Causes
    input wire logic cpu_halted,
    input wire annunc_pkg::err_evt_s err_evt,
    input wire logic bus_if_fault,
    input wire logic proc_fault,
    input wire logic host_data_server_fault_set,
    input wire logic [15:0] diag_cause,
    input wire logic [15:0] diag_history_mask,
    // Effects
    input wire annunc_pkg::lamps_s lamps,
    input wire logic [3:0] disp_code,
    input wire logic restart_req,
    input wire logic [15:0] diag_bits
);
    import annunc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////
    // Lamps follow their causes one cycle late, the host flag two cycles late
    property p_fault_src;
        bus_if_fault || proc_fault |=> lamps.fault_lamp_a && lamps.fault_lamp_b;
    endproperty
    a_fault_src: assert property (p_fault_src) else $error("fault lamps dark");
    property p_pre_active;
        disp_code != 4'h9 |=> lamps.fault_lamp_a && lamps.fault_lamp_b;
    endproperty
    a_pre_active: assert property (p_pre_active) else $error("lamps off early");
    property p_host;
        host_data_server_fault_set |-> ##2 lamps.fault_lamp_a && lamps.fault_lamp_b;
    endproperty
    a_host: assert property (p_host) else $error("host flag not shown");
    property p_halt;
        cpu_halted |=> lamps.halt_lamp;
    endproperty
    a_halt: assert property (p_halt) else $error("halt lamp dark");

    ////////////////////////////////////////
    // Error codes, restart and its aftermath
    property p_bus_err;
        err_evt.bus_err && !err_evt.addr_err |=> disp_code == 4'hb && restart_req;
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error code");
    property p_checksum;
        err_evt == 7'h08 |=> disp_code == 4'hc && !restart_req;
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum code");
    property p_restart_zero;
        restart_req |=> disp_code == 4'h0;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("code kept");
    // Static bits track the cause, history bits only drop on a restart
    property p_static;
        1'b1 |=> ((diag_bits ^ $past(diag_cause)) & ~$past(diag_history_mask)) == 16'h0;
    endproperty
    a_static: assert property (p_static) else $error("static bit wrong");
    property p_history;
        1'b1 |=> $past(restart_req)
            || ($past(diag_bits) & $past(diag_history_mask) & ~diag_bits) == 16'h0;
    endproperty
    a_history: assert property (p_history) else $error("history bit lost");

    c_parity: cover property (err_evt.parity_err);
    c_restart: cover property (restart_req);
    c_active: cover property (disp_code == 4'h9 && !lamps.fault_lamp_a);
endmodule

bind status_annunciation_logic annunc_checker chk_u (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cpu_halted(cpu_halted),
    .err_evt(err_evt),
    .bus_if_fault(bus_if_fault),
    .proc_fault(proc_fault),
    .host_data_server_fault_set(host_data_server_fault_set),
    .diag_cause(diag_cause),
    .diag_history_mask(diag_history_mask),
    .lamps(lamps),
    .disp_code(disp_code),
    .restart_req(restart_req),
    .diag_bits(diag_bits)
);

// ---- sim/tb_status_annunciation_logic.sv ----
// Self-checking bench for the annunciation block
`timescale 1ns/10ps
module tb_status_annunciation_logic;
    import annunc_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, cpu_halted = 1'b0, step_valid = 1'b0;
    logic wdog_kick = 1'b0, kick_en = 1'b1, bus_f = 1'b0, proc_f = 1'b0;
    logic hs_set = 1'b0, hs_clr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, restart_req;
    logic [7:0] cpu_load = 8'hff;
    logic [3:0] step_code = 4'h0, reg_addr = 4'h0, disp_code;
    logic [15:0] cause = 16'h0, diag_bits, seg_changes, act_on, s0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [6:0] seg;
    err_evt_s err_evt = '0;
    lamps_s lamps;
    int bad_count = 0, checked = 0, n;
    // Error rows: event, code shown, restart expected
    logic [6:0] ev [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
    logic [3:0] cd [7] = '{4'ha, 4'hb, 4'hc, 4'hc, 4'hd, 4'he, 4'hf};
    logic [0:6] rs = 7'b1110110;
    logic [6:0] sp [7] = '{7'h77, 7'h7c, 7'h39, 7'h39, 7'h5e, 7'h79, 7'h71};

    // Clock, and a steady watchdog service unless a test starves it
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) wdog_kick <= kick_en && !wdog_kick;

    status_annunciation_logic #(.FLASH_LEN(20), .LAMP_TEST_LEN(14), .BLINK_LEN(3),
        .WATCHDOG_LEN(50)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
        .cpu_halted(cpu_halted), .cpu_load(cpu_load), .step_valid(step_valid),
        .step_code(step_code), .wdog_kick(wdog_kick), .err_evt(err_evt),
        .bus_if_fault(bus_f), .proc_fault(proc_f), .host_data_server_fault_set(hs_set),
        .host_data_server_fault_clr(hs_clr), .diag_cause(cause),
        .diag_history_mask(16'h00ff), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .lamps(lamps), .seg(seg), .disp_code(disp_code),
        .restart_req(restart_req), .diag_bits(diag_bits), .reg_rdata(reg_rdata));
    panel_observer panel_u (.core_clk(core_clk), .rst_b(rst_b), .seg(seg), .lamps(lamps),
        .seg_changes(seg_changes), .act_on(act_on));

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits k edges; drives that follow land by NBA at that edge
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        cyc(1);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        cyc(1);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        cyc(1);
        reg_rd <= 1'b1;
        reg_addr <= a;
        cyc(1);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic conclude;
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        cyc(1);
        #1 chk({lamps, seg, disp_code}, 15'h7ff0);
        cyc(2);
        rst_b <= 1'b1;
        cyc(5);
        #1 chk(lamps, 4'hf);
        cyc(12);
        // Run-up walk; fault lamps stay lit until the active state
        for (int c = 1; c <= 9; c++) begin
            cyc(1);
            step_valid <= 1'b1;
            step_code <= 4'(c);
            cyc(1);
            step_valid <= 1'b0;
            cyc(1);
            #1 chk(disp_code, c);
            chk(lamps.fault_lamp_a, c != 9);
        end
        chk(seg, 7'h6f);
        rd(4'h0, 32'h25);
        rd(4'h5, 32'h0);
        cyc(1);
        bus_f <= 1'b1;
        cyc(2);
        bus_f <= 1'b0;
        proc_f <= 1'b1;
        #1 chk(lamps.fault_lamp_b, 1'b1);
        cyc(2);
        proc_f <= 1'b0;
        hs_set <= 1'b1;
        #1 chk(lamps.fault_lamp_a, 1'b1);
        cyc(1);
        hs_set <= 1'b0;
        cyc(2);
        hs_clr <= 1'b1;
        #1 chk(lamps.fault_lamp_b, 1'b1);
        cyc(1);
        hs_clr <= 1'b0;
        cyc(1);
        #1 chk(lamps.fault_lamp_a, 1'b0);
        wr(4'h2, 32'h1);
        rd(4'h2, 32'h1);
        wr(4'h2, 32'h0);
        cyc(2);
        // Halt, then a quarter workload gives 64 of 256 cycles lit
        cpu_halted <= 1'b1;
        cause <= 16'h0f0f;
        #1 chk(lamps.fault_lamp_b, 1'b0);
        cyc(2);
        cpu_halted <= 1'b0;
        cpu_load <= 8'h3f;
        cause <= 16'h0;
        #1 chk({lamps.halt_lamp, lamps.activity_lamp, diag_bits}, 18'h20f0f);
        cyc(2);
        #1 s0 = act_on;
        chk(diag_bits, 16'h000f);
        cyc(256);
        #1 chk(act_on - s0, 16'd64);
        rd(4'h1, 32'h000f);
        // Error rows; a step during the flash is ignored
        for (int i = 0; i < 7; i++) begin
            cyc(25);
            err_evt <= ev[i];
            #1 s0 = seg_changes;
            cyc(1);
            err_evt <= '0;
            step_valid <= 1'b1;
            step_code <= 4'h9;
            #1 chk({disp_code, restart_req}, {cd[i], rs[i]});
            cyc(1);
            step_valid <= 1'b0;
            #1 chk(disp_code, rs[i] ? 4'h0 : cd[i]);
            chk(seg, sp[i]);
            if (i == 0) chk(diag_bits, 16'h0);
            cyc(10);
            #1 chk(seg_changes != s0, 1'b1);
        end
        cyc(25);
        #1 s0 = seg_changes;
        cyc(10);
        #1 chk(seg_changes - s0, 16'h0);
        chk(seg, 7'h71);
        // Starve the watchdog and time the restart
        kick_en <= 1'b0;
        n = 0;
        while (restart_req !== 1'b1 && n < 200) begin
            cyc(1);
            #1 n++;
        end
        if (n == 200) begin
            bad_count++;
        end else begin
            chk(n >= 45 && n <= 55, 1'b1);
            kick_en <= 1'b1;
            cyc(1);
            #1 chk(disp_code, 4'h0);
        end
        conclude();
    end
endmodule
